// file: rtl/cpt_pkg.sv
// package: constants for the carrier / pwm timer pair
package cpt_pkg;
   localparam int unsigned CPT_CNT_W       = 8;
   localparam int unsigned CPT_SEL_BIT     = 2;
   localparam int unsigned CPT_NEXT_BIT    = 1;
   localparam int unsigned CPT_ACT_BIT     = 0;
   localparam logic [7:0]  CPT_CTRL_RESET  = 8'h00;
   localparam logic [7:0]  CPT_CNT_RESET   = 8'h00;
   localparam int unsigned CPT_START_ERR   = 1;
   typedef enum logic {CPT_MODE_CARRIER, CPT_MODE_PWM} cpt_mode_t;
endpackage : cpt_pkg

// file: rtl/carrier_pwm_timer.sv
// carrier generator / pwm timer built from two 8-bit timers counting separate ticks
`timescale 1ns/1ns
// What this block does
// - output select bit 2, zero means carrier
// - control bit 1 next gate, bit 0 active
// - low match pulses irq, toggles output, swaps compare
// - alternating low matches repeat into carrier clock
// - high match pulses irq, reloads gate bit
// - carrier mode: pin carries carrier only while gate is one; pwm mode ignores the gate
// - next gate bit rewritten before restart
// - pwm low width first, high width second
// - pwm first compare match clears low counter
// - pwm second compare match clears low counter
// - output forced low while pin disabled
// - first match may come up to one count early
module carrier_pwm_timer
   import cpt_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       countTick,
   input  wire logic       periodTick,
   input  wire logic       modePwm,
   input  wire logic       carrierRunEnable,
   input  wire logic       periodRunEnable,
   input  wire logic       pinOutputEnable,
   input  wire logic [7:0] periodCompare,
   input  wire logic [7:0] carrierLowCompare,
   input  wire logic [7:0] carrierHighCompare,
   input  wire logic       ctrlWrite,
   input  wire logic [7:0] ctrlData,
   output logic            timerOutputPin,
   output logic            carrierMatchIrq,
   output logic            periodMatchIrq,
   output logic [7:0]      lowCarrierCounter,
   output logic [7:0]      highPeriodCounter
);
   typedef struct packed {
      logic [7:0] lowCnt;
      logic [7:0] highCnt;
      logic       useHigh;
      logic       carrier;
      logic       outputSelect;
      logic       nextGate;
      logic       activeGate;
      logic       pin;
      logic       lowIrq;
      logic       highIrq;
   } cpt_state_t;

   cpt_state_t st;
   cpt_state_t next_st;
   logic [7:0] activeCompare;
   logic       lowMatch;
   logic       highMatch;
   logic       waveLevel;

   assign activeCompare = st.useHigh ? carrierHighCompare : carrierLowCompare;
   // compare only on a count pulse so a stalled count clock cannot re-fire
   assign lowMatch  = carrierRunEnable && countTick && (st.lowCnt == activeCompare);
   assign highMatch = periodRunEnable && !modePwm && periodTick
                      && (st.highCnt == periodCompare);

   always_comb
   begin
      next_st = st;
      next_st.lowIrq  = 1'b0;
      next_st.highIrq = 1'b0;
      if (ctrlWrite)
      begin
         // whole-byte write only; bits 7..3 are not stored
         next_st.outputSelect = ctrlData[CPT_SEL_BIT];
         next_st.nextGate     = ctrlData[CPT_NEXT_BIT];
         next_st.activeGate   = ctrlData[CPT_ACT_BIT];
      end
      if (!carrierRunEnable)
      begin
         // stop clears the counter and the wave; start is not aligned to the tick
         next_st.lowCnt  = CPT_CNT_RESET;
         next_st.useHigh = 1'b0;
         next_st.carrier = 1'b0;
         // next gate is not retained over a stop
         if (!ctrlWrite)
            next_st.nextGate = 1'b0;
      end
      else if (lowMatch)
      begin
         next_st.lowIrq  = 1'b1;
         next_st.carrier = !st.carrier;
         next_st.useHigh = !st.useHigh;
         next_st.lowCnt  = CPT_CNT_RESET;
      end
      else if (countTick)
         next_st.lowCnt = st.lowCnt + 8'h01;
      if (!periodRunEnable || modePwm)
         next_st.highCnt = CPT_CNT_RESET;
      else if (highMatch)
      begin
         next_st.highIrq = 1'b1;
         next_st.highCnt = CPT_CNT_RESET;
      end
      else if (periodTick)
         next_st.highCnt = st.highCnt + 8'h01;
      // irq rising edge reloads the gate; hardware reload beats a write
      if (highMatch && !st.highIrq)
         next_st.activeGate = st.nextGate;
      next_st.pin = pinOutputEnable ? waveLevel : 1'b0;
   end

   always_comb
   begin
      if (modePwm)
         waveLevel = st.carrier;
      else if (st.outputSelect)
         waveLevel = st.activeGate;
      else
         waveLevel = st.carrier && st.activeGate;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         st <= '0;
      end
      else
         st <= next_st;
   end

   assign timerOutputPin    = st.pin;
   assign carrierMatchIrq   = st.lowIrq;
   assign periodMatchIrq    = st.highIrq;
   assign lowCarrierCounter = st.lowCnt;
   assign highPeriodCounter = st.highCnt;

   property p_low_match;
      @(posedge clock) disable iff (!rst_n)
      lowMatch |=> carrierMatchIrq && lowCarrierCounter == 8'h00 && $changed(st.useHigh);
   endproperty
   a_low_match: assert property (p_low_match) else $error("low match effects missing");

   property p_toggle;
      @(posedge clock) disable iff (!rst_n)
      lowMatch |=> st.carrier != $past(st.carrier);
   endproperty
   a_toggle: assert property (p_toggle) else $error("carrier did not toggle");

   property p_high_match;
      @(posedge clock) disable iff (!rst_n)
      highMatch |=> periodMatchIrq && highPeriodCounter == CPT_CNT_RESET;
   endproperty
   a_high_match: assert property (p_high_match) else $error("period match missing");

   property p_reload;
      @(posedge clock) disable iff (!rst_n)
      (highMatch && !periodMatchIrq) |=> st.activeGate == $past(st.nextGate);
   endproperty
   a_reload: assert property (p_reload) else $error("gate not reloaded");

   property p_gate;
      @(posedge clock) disable iff (!rst_n)
      (!modePwm && !st.outputSelect && !st.activeGate) |=> !timerOutputPin;
   endproperty
   a_gate: assert property (p_gate) else $error("pin active with gate low");

   property p_pin_low;
      @(posedge clock) disable iff (!rst_n)
      !pinOutputEnable |=> !timerOutputPin;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin not low while disabled");

   property p_pwm_clear;
      @(posedge clock) disable iff (!rst_n)
      (modePwm && lowMatch) |=> lowCarrierCounter == CPT_CNT_RESET && carrierMatchIrq;
   endproperty
   a_pwm_clear: assert property (p_pwm_clear) else $error("pwm count not cleared");

   // the pin trails the wave by one register stage in both modes
   property p_pin_follow;
      @(posedge clock) disable iff (!rst_n)
      (modePwm && pinOutputEnable) |=> timerOutputPin == $past(st.carrier);
   endproperty
   a_pin_follow: assert property (p_pin_follow) else $error("pwm pin off the wave");

   property p_carrier_out;
      @(posedge clock) disable iff (!rst_n)
      (!modePwm && !st.outputSelect && pinOutputEnable) |=>
         timerOutputPin == ($past(st.carrier) && $past(st.activeGate));
   endproperty
   a_carrier_out: assert property (p_carrier_out) else $error("gated carrier wrong");

   property p_pwm_idle;
      @(posedge clock) disable iff (!rst_n)
      modePwm |=> highPeriodCounter == CPT_CNT_RESET && !periodMatchIrq;
   endproperty
   a_pwm_idle: assert property (p_pwm_idle) else $error("period timer ran in pwm");

   property p_stop_clear;
      @(posedge clock) disable iff (!rst_n)
      (!carrierRunEnable && !ctrlWrite) |=> !st.nextGate && lowCarrierCounter == CPT_CNT_RESET;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("stop left state behind");

   property p_write;
      @(posedge clock) disable iff (!rst_n)
      ctrlWrite |=> st.outputSelect == $past(ctrlData[CPT_SEL_BIT])
                    && st.nextGate == $past(ctrlData[CPT_NEXT_BIT]);
   endproperty
   a_write: assert property (p_write) else $error("control write lost");

   // a reload in the same cycle owns the active gate, so only clean writes are judged
   property p_write_gate;
      @(posedge clock) disable iff (!rst_n)
      (ctrlWrite && !highMatch) |=> st.activeGate == $past(ctrlData[CPT_ACT_BIT]);
   endproperty
   a_write_gate: assert property (p_write_gate) else $error("active gate write lost");

   c_low:    cover property (@(posedge clock) disable iff (!rst_n)
                             !modePwm && lowMatch && st.useHigh && st.activeGate);
   c_high:   cover property (@(posedge clock) disable iff (!rst_n) highMatch && st.nextGate);
   c_pwm:    cover property (@(posedge clock) disable iff (!rst_n)
                             modePwm && lowMatch && st.useHigh);
   c_select: cover property (@(posedge clock) disable iff (!rst_n)
                             st.outputSelect && timerOutputPin);
endmodule : carrier_pwm_timer

// file: dv/cpt_ir_load.sv
// partner model: emitter load that measures the pin waveform
`timescale 1ns/1ns
module cpt_ir_load
(
   input  wire logic       clock,
   input  wire logic       drive,
   input  wire logic       clear,
   output logic [7:0]      highWidth,
   output logic [7:0]      lowWidth,
   output logic [7:0]      edges
);
   logic       last;
   logic [7:0] run;
   always_ff @(posedge clock)
   begin
      last <= drive;
      if (clear)
      begin
         edges <= 8'h00;
         run   <= 8'h00;
      end
      else if (drive != last)
      begin
         edges <= edges + 8'h01;
         run   <= 8'h01;
         if (last)
            highWidth <= run;
         else
            lowWidth <= run;
      end
      else
         run <= run + 8'h01;
   end
endmodule : cpt_ir_load

// file: dv/carrier_pwm_timer_tb.sv
// testbench: pwm widths, carrier gating and output select
`timescale 1ns/1ns
module carrier_pwm_timer_tb;
   import cpt_pkg::*;
   logic       clock, rst_n, countTick, periodTick, modePwm, carrierRunEnable;
   logic       periodRunEnable, pinOutputEnable, ctrlWrite, clear;
   logic [7:0] periodCompare, carrierLowCompare, carrierHighCompare, ctrlData;
   logic       timerOutputPin, carrierMatchIrq, periodMatchIrq;
   logic [7:0] lowCarrierCounter, highPeriodCounter, highWidth, lowWidth, edges;
   int         failures, n_compared, cycles, irqs, pirqs;
   int         tickDiv = 1;
   carrier_pwm_timer DUT (.clock(clock), .rst_n(rst_n), .countTick(countTick),
      .periodTick(periodTick), .modePwm(modePwm), .carrierRunEnable(carrierRunEnable),
      .periodRunEnable(periodRunEnable), .pinOutputEnable(pinOutputEnable),
      .periodCompare(periodCompare), .carrierLowCompare(carrierLowCompare),
      .carrierHighCompare(carrierHighCompare), .ctrlWrite(ctrlWrite), .ctrlData(ctrlData),
      .timerOutputPin(timerOutputPin), .carrierMatchIrq(carrierMatchIrq),
      .periodMatchIrq(periodMatchIrq), .lowCarrierCounter(lowCarrierCounter),
      .highPeriodCounter(highPeriodCounter));
   cpt_ir_load load (.clock(clock), .drive(timerOutputPin), .clear(clear),
      .highWidth(highWidth), .lowWidth(lowWidth), .edges(edges));
   initial
   begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   task tally_and_finish;
      if (failures == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   always @(posedge clock)
   begin
      cycles++;
      irqs += carrierMatchIrq;
      pirqs += periodMatchIrq;
      if (cycles == 3000)
      begin
         failures++;
         tally_and_finish();
      end
   end
   // count pulse every tickDiv clocks, changed just after the edge
   always @(posedge clock)
   begin
      #1;
      countTick = (cycles % tickDiv) == 0;
   end
   task step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   task check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check
   task write_ctrl(input logic [7:0] d);
      ctrlData = d;
      ctrlWrite = 1;
      step(1);
      ctrlWrite = 0;
   endtask : write_ctrl
   task stop_all;
      carrierRunEnable = 0;
      periodRunEnable = 0;
      pinOutputEnable = 0;
      step(1);
   endtask : stop_all
   task measure(input int n);
      clear = 1;
      step(1);
      clear = 0;
      step(n);
   endtask : measure
   task test_pwm;
      stop_all();
      carrierLowCompare = 8'h02;
      carrierHighCompare = 8'h04;
      modePwm = 1;
      pinOutputEnable = 1;
      step(1);
      check("pin at enable", 8'h00, timerOutputPin);
      carrierRunEnable = 1;
      measure(30);
      check("pwm low width", 8'h03, lowWidth);
      check("pwm high width", 8'h05, highWidth);
   endtask : test_pwm
   task test_carrier;
      stop_all();
      carrierLowCompare = 8'h01;
      carrierHighCompare = 8'h01;
      periodCompare = 8'h03;
      modePwm = 0;
      write_ctrl(8'h00);
      pinOutputEnable = 1;
      carrierRunEnable = 1;
      periodRunEnable = 1;
      measure(20);
      check("edges gate off", 8'h00, edges);
      write_ctrl(8'h03);
      irqs = 0;
      step(20);
      check("carrier irqs", 8'h0A, 8'(irqs));
      check("carrier high", 8'h02, highWidth);
      write_ctrl(8'h01);
      step(10);
      measure(20);
      check("edges after reload", 8'h00, edges);
      write_ctrl(8'h07);
      step(10);
      check("level select", 8'h01, timerOutputPin);
      stop_all();
      step(1);
      check("counter stopped", 8'h00, lowCarrierCounter);
   endtask : test_carrier
   task test_restart;
      write_ctrl(8'h03);
      pinOutputEnable = 1;
      carrierRunEnable = 1;
      periodRunEnable = 1;
      pirqs = 0;
      measure(20);
      check("restart edges", 8'h09, edges);
      check("restart low", 8'h02, lowWidth);
      check("period irqs", 8'h05, 8'(pirqs));
      check("period counter", 8'h01, highPeriodCounter);
      check("carrier counter", 8'h01, lowCarrierCounter);
      stop_all();
      step(1);
      check("period stopped", 8'h00, highPeriodCounter);
   endtask : test_restart
   task test_pwm_slow;
      stop_all();
      tickDiv = 2;
      carrierLowCompare = 8'h02;
      carrierHighCompare = 8'h04;
      modePwm = 1;
      pinOutputEnable = 1;
      step(1);
      carrierRunEnable = 1;
      measure(40);
      check("slow pwm low width", 8'h06, lowWidth);
      check("slow pwm high width", 8'h0A, highWidth);
      tickDiv = 1;
   endtask : test_pwm_slow
   initial
   begin
      {rst_n, modePwm, carrierRunEnable, periodRunEnable, pinOutputEnable} = '0;
      {ctrlWrite, clear, periodCompare, carrierLowCompare} = '0;
      {carrierHighCompare, ctrlData, failures, n_compared, cycles, irqs, pirqs} = '0;
      periodTick = 1;
      step(4);
      rst_n = 1;
      step(1);
      check("pin after reset", 8'h00, timerOutputPin);
      check("counter after reset", 8'h00, highPeriodCounter);
      test_pwm();
      test_carrier();
      test_restart();
      test_pwm_slow();
      tally_and_finish();
   end
endmodule : carrier_pwm_timer_tb
